// ===== hw/seg_router_pkg.sv
// Constants for the legacy segment router: register offsets, fields,
// reset values, attribute codes and address windows.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package seg_router_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   // Printed offsets are not word aligned: byte address = 4 * index
   localparam logic [7:0] IDX_SEG_ATTR = 8'h51;
   localparam logic [7:0] IDX_DIMM_POP = 8'h52;
   localparam logic [7:0] IDX_HUB_CFG = 8'h50;
   localparam logic [7:0] IDX_SYS_MGMT_RAM_CONTROL_CTL = 8'h70;
   localparam logic [7:0] IDX_STATUS = 8'h80;
   localparam int ADDR_W = 10;
   localparam logic [ADDR_W-1:0] BYTE_SEG_ATTR = {IDX_SEG_ATTR, 2'b00};
   localparam logic [ADDR_W-1:0] BYTE_DIMM_POP = {IDX_DIMM_POP, 2'b00};
   localparam logic [ADDR_W-1:0] BYTE_HUB_CFG = {IDX_HUB_CFG, 2'b00};
   localparam logic [ADDR_W-1:0] BYTE_SYS_MGMT_RAM_CONTROL_CTL = {IDX_SYS_MGMT_RAM_CONTROL_CTL, 2'b00};
   localparam logic [ADDR_W-1:0] BYTE_STATUS = {IDX_STATUS, 2'b00};

   // -----------------------------------------------------------------
   // Reset values and fields
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_SEG_ATTR = 8'h00;
   localparam logic [7:0] RST_DIMM_POP = 8'h00;
   localparam logic [7:0] RST_HUB_CFG = 8'h00;
   localparam logic [7:0] RST_SYS_MGMT_RAM_CONTROL_CTL = 8'h00;
   localparam int CD_HOLE_BIT = 0;      // hub config: cd_hole_forward_enable
   localparam int GFX_SEL_BIT = 0;      // sys_mgmt_ram_control ctl: graphics mode select
   localparam int VGA_SMM_BIT = 1;      // sys_mgmt_ram_control ctl: window is SYSTEM_MANAGEMENT_MODE memory
   localparam int LOCK_BIT = 4;         // sys_mgmt_ram_control ctl: sys_mgmt_space_lock
   localparam int SEG_F_LSB = 6;
   localparam int SEG_E_LSB = 4;
   localparam int SEG_D_LSB = 2;
   localparam int SEG_C_LSB = 0;
   localparam int DIMM1_LSB = 4;
   localparam int DIMM0_LSB = 0;
   localparam int NUM_SEG = 4;
   localparam int NUM_ROWS = 4;
   localparam int ROW_BITS = 64;

   // -----------------------------------------------------------------
   // Attribute codes and destinations
   // -----------------------------------------------------------------
   localparam logic [1:0] ATTR_OFF = 2'b00;
   localparam logic [1:0] ATTR_RO = 2'b01;
   localparam logic [1:0] ATTR_WO = 2'b10;
   localparam logic [1:0] ATTR_RW = 2'b11;

   typedef enum logic [1:0] {
      DEST_DRAM = 2'b00,
      DEST_HUB = 2'b01,
      DEST_GFX = 2'b11,
      DEST_REFUSE = 2'b10
   } dest_e;

   // -----------------------------------------------------------------
   // Address windows (20-bit host addresses)
   // -----------------------------------------------------------------
   localparam int HADDR_W = 20;
   localparam logic [3:0] SEG_C_TOP = 4'hC;
   localparam logic [3:0] SEG_D_TOP = 4'hD;
   localparam logic [3:0] SEG_E_TOP = 4'hE;
   localparam logic [3:0] SEG_F_TOP = 4'hF;
   localparam logic [3:0] VGA_A_TOP = 4'hA;
   localparam logic [3:0] VGA_B_TOP = 4'hB;
   localparam logic [5:0] CD_HOLE_TOP6 = 6'h37;   // DC000h >> 14
   localparam logic [19:0] DRAM_BASE = 20'h00000;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

endpackage

// ===== hw/dimm_size_decode.sv
// Decodes a 4-bit DIMM population code to its size in megabytes.
// Assumes a purely combinational caller; code 2 has no meaning.
`timescale 1ns/1ps
`default_nettype none
module dimm_size_decode (
   input wire logic [3:0] code_i,
   output logic [8:0] size_mb_o,
   output logic valid_o
);
   import seg_router_pkg::*;

   // -----------------------------------------------------------------
   // Size table
   // -----------------------------------------------------------------
   // Code 2 reports zero and invalid; software must not program it
   always_comb begin
      valid_o = 1'b1;
      case (code_i)
         4'h0: size_mb_o = 9'h000;
         4'h1: size_mb_o = 9'h008;
         4'h3, 4'h4: size_mb_o = 9'h010;
         4'h5: size_mb_o = 9'h018;
         4'h6, 4'h7: size_mb_o = 9'h020;
         4'h8: size_mb_o = 9'h030;
         4'h9, 4'hA: size_mb_o = 9'h040;
         4'hB: size_mb_o = 9'h060;
         4'hC, 4'hD: size_mb_o = 9'h080;
         4'hE: size_mb_o = 9'h0C0;
         4'hF: size_mb_o = 9'h100;
         default: begin
            size_mb_o = 9'h000;
            valid_o = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

// ===== hw/segment_route_decode.sv
// Combinational route decision for one host cycle in the legacy area.
// Assumes register fields are stable, driven from the same clock.
`timescale 1ns/1ps
`default_nettype none
module segment_route_decode (
   input wire logic [19:0] addr_i,
   input wire logic is_write_i,
   input wire logic from_hub_i,
   input wire logic in_smm_i,
   input wire logic [7:0] seg_attr_i,
   input wire logic cd_hole_en_i,
   input wire logic gfx_sel_i,
   input wire logic vga_smm_i,
   output seg_router_pkg::dest_e dest_o
);
   import seg_router_pkg::*;

   // -----------------------------------------------------------------
   // Attribute interpretation
   // -----------------------------------------------------------------
   function automatic dest_e attr_dest(input logic [1:0] attr, input logic wr);
      dest_e d;
      d = DEST_HUB;
      case (attr)
         ATTR_OFF: d = DEST_HUB;
         ATTR_RO: d = wr ? DEST_HUB : DEST_DRAM;
         ATTR_WO: d = wr ? DEST_DRAM : DEST_HUB;
         ATTR_RW: d = DEST_DRAM;
         default: d = DEST_HUB;
      endcase
      return d;
   endfunction

   logic [3:0] top;
   assign top = addr_i[19:16];

   // Priority: video window, CD hole, then segment fields, else DRAM
   always_comb begin
      dest_o = DEST_DRAM;
      if (top == VGA_A_TOP || top == VGA_B_TOP) begin
         if (vga_smm_i && from_hub_i) begin
            dest_o = DEST_REFUSE;
         end else if (vga_smm_i && in_smm_i) begin
            dest_o = DEST_DRAM;
         end else begin
            dest_o = gfx_sel_i ? DEST_GFX : DEST_HUB;
         end
      end else if (top == SEG_F_TOP) begin
         dest_o = attr_dest(seg_attr_i[SEG_F_LSB +: 2], is_write_i);
      end else if (top == SEG_E_TOP) begin
         dest_o = attr_dest(seg_attr_i[SEG_E_LSB +: 2], is_write_i);
      end else if (top == SEG_D_TOP) begin
         if (cd_hole_en_i && addr_i[19:14] == CD_HOLE_TOP6) begin
            dest_o = DEST_HUB;
         end else begin
            dest_o = attr_dest(seg_attr_i[SEG_D_LSB +: 2], is_write_i);
         end
      end else if (top == SEG_C_TOP) begin
         dest_o = attr_dest(seg_attr_i[SEG_C_LSB +: 2], is_write_i);
      end
   end
endmodule
`default_nettype wire

// ===== hw/legacy_segment_router.sv
// Legacy segment router top: register file on Avalon-MM, host cycle
// routing for C0000h-FFFFFh and the video window, DIMM size report.
// Assumes host cycle strobes come from logic on clock_i.
`timescale 1ns/1ps
`default_nettype none
module legacy_segment_router #(
   parameter int NUM_DIMMS = 2
) (
   input wire logic clock_i,
   input wire logic rstn_i,
   // Avalon-MM register slave
   input wire logic [seg_router_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [1:0] avs_response_o,
   // Host cycle to be routed
   input wire logic host_valid_i,
   input wire logic [19:0] host_addr_i,
   input wire logic host_write_i,
   input wire logic host_from_hub_i,
   input wire logic host_smm_i,
   output logic route_valid_o,
   output logic [1:0] route_dest_o,
   // DIMM size report
   output logic [8:0] dimm0_size_mb_o,
   output logic [8:0] dimm1_size_mb_o,
   output logic [9:0] total_size_mb_o
);
   import seg_router_pkg::*;

   // -----------------------------------------------------------------
   // Reset synchroniser
   // -----------------------------------------------------------------
   logic rst_meta_q;
   logic rst_sync_q;
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   logic rstn;
   assign rstn = rst_sync_q;

   // -----------------------------------------------------------------
   // Register state
   // -----------------------------------------------------------------
   logic [7:0] seg_attr_q;
   logic [7:0] dimm_pop_q;
   logic [7:0] hub_cfg_q;
   logic [7:0] sys_mgmt_ram_control_ctl_q;
   logic [7:0] refused_cnt_q;
   logic lock_hit_q;

   // Answer one cycle after the request; waitrequest high on entry
   logic ack_q;
   logic req;
   logic do_wr;
   assign req = (avs_read_i || avs_write_i) && !ack_q;
   // Write lands only at the edge where waitrequest is seen low
   assign do_wr = avs_write_i && ack_q && avs_byteenable_i[0];

   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
      return a == b;
   endfunction

   logic locked;
   assign locked = sys_mgmt_ram_control_ctl_q[LOCK_BIT];

   // Segment attributes, reset to all segments forwarded
   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         seg_attr_q <= RST_SEG_ATTR;
      end else if (do_wr && hit(avs_address_i, BYTE_SEG_ATTR)) begin
         seg_attr_q <= avs_writedata_i[7:0];
      end
   end

   // Population register freezes once the lock is set
   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         dimm_pop_q <= RST_DIMM_POP;
      end else if (do_wr && hit(avs_address_i, BYTE_DIMM_POP) && !locked) begin
         dimm_pop_q <= avs_writedata_i[7:0];
      end
   end

   // Sticky flag: a write was dropped because of the lock
   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         lock_hit_q <= 1'b0;
      end else if (do_wr && hit(avs_address_i, BYTE_DIMM_POP) && locked) begin
         lock_hit_q <= 1'b1;
      end
   end

   // Hub config holds the CD hole enable
   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         hub_cfg_q <= RST_HUB_CFG;
      end else if (do_wr && hit(avs_address_i, BYTE_HUB_CFG)) begin
         hub_cfg_q <= avs_writedata_i[7:0];
      end
   end

   // Lock bit can only be set, cleared by reset alone
   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         sys_mgmt_ram_control_ctl_q <= RST_SYS_MGMT_RAM_CONTROL_CTL;
      end else if (do_wr && hit(avs_address_i, BYTE_SYS_MGMT_RAM_CONTROL_CTL)) begin
         sys_mgmt_ram_control_ctl_q <= avs_writedata_i[7:0];
         sys_mgmt_ram_control_ctl_q[LOCK_BIT] <= avs_writedata_i[LOCK_BIT] | locked;
      end
   end

   // -----------------------------------------------------------------
   // DIMM size decode
   // -----------------------------------------------------------------
   logic [8:0] size_mb [NUM_DIMMS];
   logic [NUM_DIMMS-1:0] code_ok;
   genvar g;
   generate
      for (g = 0; g < NUM_DIMMS; g++) begin : g_dimm
         // DIMM g code sits at bits 4g+3:4g
         dimm_size_decode u_dec (
            .code_i(dimm_pop_q[4*g +: 4]),
            .size_mb_o(size_mb[g]),
            .valid_o(code_ok[g])
         );
      end
   endgenerate

   // Registered size outputs; two DIMMs of two 64-bit rows each
   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         dimm0_size_mb_o <= 9'h000;
         dimm1_size_mb_o <= 9'h000;
         total_size_mb_o <= 10'h000;
      end else begin
         dimm0_size_mb_o <= size_mb[0];
         dimm1_size_mb_o <= size_mb[1];
         total_size_mb_o <= {1'b0, size_mb[0]} + {1'b0, size_mb[1]};
      end
   end

   // -----------------------------------------------------------------
   // Host cycle routing
   // -----------------------------------------------------------------
   dest_e dest;
   segment_route_decode u_route (
      .addr_i(host_addr_i),
      .is_write_i(host_write_i),
      .from_hub_i(host_from_hub_i),
      .in_smm_i(host_smm_i),
      .seg_attr_i(seg_attr_q),
      .cd_hole_en_i(hub_cfg_q[CD_HOLE_BIT]),
      .gfx_sel_i(sys_mgmt_ram_control_ctl_q[GFX_SEL_BIT]),
      .vga_smm_i(sys_mgmt_ram_control_ctl_q[VGA_SMM_BIT]),
      .dest_o(dest)
   );

   // Decision registered one cycle after the cycle strobe
   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         route_valid_o <= 1'b0;
         route_dest_o <= DEST_HUB;
      end else begin
         route_valid_o <= host_valid_i;
         route_dest_o <= host_valid_i ? dest : DEST_HUB;
      end
   end

   // Count refused hub accesses to the SYSTEM_MANAGEMENT_MODE video window
   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         refused_cnt_q <= 8'h00;
      end else if (host_valid_i && dest == DEST_REFUSE && refused_cnt_q != 8'hFF) begin
         refused_cnt_q <= refused_cnt_q + 8'h01;
      end
   end

   // -----------------------------------------------------------------
   // Read data and response
   // -----------------------------------------------------------------
   logic [31:0] rd_d;
   logic mapped;
   always_comb begin
      mapped = 1'b1;
      rd_d = UNMAPPED_DATA;
      if (hit(avs_address_i, BYTE_SEG_ATTR)) begin
         rd_d[7:0] = seg_attr_q;
      end else if (hit(avs_address_i, BYTE_DIMM_POP)) begin
         rd_d[7:0] = dimm_pop_q;
      end else if (hit(avs_address_i, BYTE_HUB_CFG)) begin
         rd_d[7:0] = hub_cfg_q;
      end else if (hit(avs_address_i, BYTE_SYS_MGMT_RAM_CONTROL_CTL)) begin
         rd_d[7:0] = sys_mgmt_ram_control_ctl_q;
      end else if (hit(avs_address_i, BYTE_STATUS)) begin
         rd_d = {12'h000, refused_cnt_q, 7'h00, lock_hit_q, 2'b00, code_ok};
      end else begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         avs_readdata_o <= 32'h0000_0000;
         avs_response_o <= 2'b00;
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_readdata_o <= (req && avs_read_i) ? rd_d : 32'h0000_0000;
         avs_response_o <= (req && !mapped) ? 2'b11 : 2'b00;
         avs_waitrequest_o <= !req;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/host_cycle_model.sv
// Host bus model: presents one routed host cycle per request pulse.
// Assumes requests arrive on clock_i from the bench, one at a time.
`timescale 1ns/1ps
`default_nettype none
module host_cycle_model (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic req_i,
   input wire logic [19:0] addr_i,
   input wire logic write_i,
   input wire logic hub_i,
   input wire logic smm_i,
   output logic host_valid_o,
   output logic [19:0] host_addr_o,
   output logic host_write_o,
   output logic host_from_hub_o,
   output logic host_smm_o
);
   // --------------------------------------------------------------
   // Cycle launch
   // --------------------------------------------------------------
   // Idle qualifiers invert each cycle so a stale value never looks valid
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         host_valid_o <= 1'b0;
         host_addr_o <= 20'h5A5A5;
         host_write_o <= 1'b0;
         host_from_hub_o <= 1'b0;
         host_smm_o <= 1'b0;
      end else begin
         host_valid_o <= req_i;
         host_addr_o <= req_i ? addr_i : ~host_addr_o;
         host_write_o <= req_i ? write_i : ~host_write_o;
         host_from_hub_o <= req_i ? hub_i : ~host_from_hub_o;
         host_smm_o <= req_i ? smm_i : ~host_smm_o;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/legacy_segment_router_props.sv
// Port checker for the legacy segment router.
// Assumes one clock domain; attached by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module legacy_segment_router_props
   import seg_router_pkg::*;
#(
   parameter int NUM_DIMMS = 2
) (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic [seg_router_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [1:0] avs_response_o,
   input wire logic host_valid_i,
   input wire logic [19:0] host_addr_i,
   input wire logic host_from_hub_i,
   input wire logic route_valid_o,
   input wire logic [1:0] route_dest_o,
   input wire logic [8:0] dimm0_size_mb_o,
   input wire logic [8:0] dimm1_size_mb_o,
   input wire logic [9:0] total_size_mb_o
);
   // --------------------------------------------------------------
   // Helpers and sequences
   // --------------------------------------------------------------
   logic mapped;
   // Decoded register words; anything else answers with an error
   assign mapped = avs_address_i inside {BYTE_SEG_ATTR, BYTE_DIMM_POP, BYTE_HUB_CFG,
                                          BYTE_SYS_MGMT_RAM_CONTROL_CTL, BYTE_STATUS};
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   sequence s_req; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
   sequence s_ans; !avs_waitrequest_o; endsequence
   property p_ans_next; s_req |=> s_ans; endproperty
   property p_ans_cause; $fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i); endproperty
   property p_ans_short; s_ans |=> avs_waitrequest_o; endproperty
   property p_unmapped; s_req and !mapped |=> s_ans and avs_response_o == 2'b11
      && avs_readdata_o == 32'h0000_0000; endproperty
   property p_mapped; s_req and mapped |=> avs_response_o == 2'b00; endproperty
   property p_route_lat; host_valid_i |=> route_valid_o; endproperty
   property p_route_idle; !host_valid_i |=> !route_valid_o && route_dest_o == 2'b01; endproperty
   property p_refuse; route_valid_o && route_dest_o == 2'b10 |-> $past(host_from_hub_i)
      && $past(host_addr_i[19:17]) == 3'b101; endproperty
   property p_gfx; route_valid_o && route_dest_o == 2'b11
      |-> $past(host_addr_i[19:17]) == 3'b101; endproperty
   property p_size; dimm0_size_mb_o inside {9'h000, 9'h008, 9'h010, 9'h018, 9'h020, 9'h030,
      9'h040, 9'h060, 9'h080, 9'h0C0, 9'h100}; endproperty
   property p_total; ($stable(dimm0_size_mb_o) && $stable(dimm1_size_mb_o)) [*2]
      |-> total_size_mb_o == {1'b0, dimm0_size_mb_o} + {1'b0, dimm1_size_mb_o}; endproperty
   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   a_ans_next: assert property (p_ans_next) else $error("bus answer late");
   a_ans_cause: assert property (p_ans_cause) else $error("answer without request");
   a_ans_short: assert property (p_ans_short) else $error("answer held too long");
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   a_mapped: assert property (p_mapped) else $error("mapped access refused");
   a_route_lat: assert property (p_route_lat) else $error("route result missing");
   a_route_idle: assert property (p_route_idle) else $error("route result without cycle");
   a_refuse: assert property (p_refuse) else $error("refusal outside hub video access");
   a_gfx: assert property (p_gfx) else $error("graphics outside video window");
   a_size: assert property (p_size) else $error("unlisted DIMM size");
   a_total: assert property (p_total) else $error("total size not the sum");
endmodule
bind legacy_segment_router legacy_segment_router_props #(.NUM_DIMMS(NUM_DIMMS)) u_props (
   .clock_i(clock_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
   .host_valid_i(host_valid_i), .host_addr_i(host_addr_i), .host_from_hub_i(host_from_hub_i),
   .route_valid_o(route_valid_o), .route_dest_o(route_dest_o),
   .dimm0_size_mb_o(dimm0_size_mb_o), .dimm1_size_mb_o(dimm1_size_mb_o),
   .total_size_mb_o(total_size_mb_o));
`default_nettype wire

// ===== testbench/legacy_segment_router_tb.sv
// Self-checking bench for the legacy segment router.
// Assumes the host cycle model and the bound checker beside it.
`timescale 1ns/1ps
`default_nettype none
module legacy_segment_router_tb;
   import seg_router_pkg::*;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [ADDR_W-1:0] adr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = '0;
   logic [31:0] rdat;
   logic waitreq;
   logic [1:0] resp;
   logic req = 1'b0;
   logic [19:0] r_addr = '0;
   logic r_write = 1'b0;
   logic r_hub = 1'b0;
   logic r_smm = 1'b0;
   logic h_valid, h_write, h_hub, h_smm, rvalid;
   logic [19:0] h_addr;
   logic [1:0] rdest;
   logic [8:0] d0, d1;
   logic [9:0] tot;
   logic [31:0] bq;
   logic [1:0] br;
   int err_count = 0;
   int checked = 0;
   // Size in MB per population code; code 2 reads as empty
   localparam logic [8:0] size_tab [16] = '{9'h000, 9'h008, 9'h000, 9'h010, 9'h010,
      9'h018, 9'h020, 9'h020, 9'h030, 9'h040, 9'h040, 9'h060, 9'h080, 9'h080, 9'h0C0, 9'h100};
   // --------------------------------------------------------------
   // Design, host model and clock
   // --------------------------------------------------------------
   legacy_segment_router u_legacy_segment_router (.clock_i(clock_i), .rstn_i(rstn_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq),
      .avs_response_o(resp), .host_valid_i(h_valid), .host_addr_i(h_addr),
      .host_write_i(h_write), .host_from_hub_i(h_hub), .host_smm_i(h_smm),
      .route_valid_o(rvalid), .route_dest_o(rdest), .dimm0_size_mb_o(d0),
      .dimm1_size_mb_o(d1), .total_size_mb_o(tot));
   host_cycle_model u_host_cycle_model (.clock_i(clock_i), .rstn_i(rstn_i), .req_i(req),
      .addr_i(r_addr), .write_i(r_write), .hub_i(r_hub), .smm_i(r_smm),
      .host_valid_o(h_valid), .host_addr_o(h_addr), .host_write_o(h_write),
      .host_from_hub_o(h_hub), .host_smm_o(h_smm));
   // Free-running 125 MHz clock
   initial begin
      forever #4 clock_i = ~clock_i;
   end
   // --------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------
   task automatic tally_and_finish();
      if (err_count == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Avalon master: hold request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clock_i);
      adr <= a;
      wdat <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clock_i);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      q = rdat;
      r = resp;
      rd <= 1'b0;
      wr <= 1'b0;
      if (waitreq !== 1'b0) begin
         err_count++;
         tally_and_finish();
      end
   endtask
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
      bus(1'b0, a, 32'h0, bq, br);
      chk("readdata", bq, e);
      chk("response", br, er);
   endtask
   // One host cycle through the model, then its routing result
   task automatic hcyc(input logic [19:0] a, input logic w, input logic hub, input logic system_management_mode,
                       input logic [1:0] e);
      int n;
      n = 0;
      @(posedge clock_i);
      req <= 1'b1;
      r_addr <= a;
      r_write <= w;
      r_hub <= hub;
      r_smm <= system_management_mode;
      @(posedge clock_i);
      req <= 1'b0;
      do begin
         @(posedge clock_i);
         #1;
         n++;
      end while (rvalid !== 1'b1 && n < 6);
      chk("route_valid", rvalid, 32'h1);
      chk("route_dest", rdest, e);
   endtask
   // --------------------------------------------------------------
   // Main sequence and watchdog
   // --------------------------------------------------------------
   initial begin
      int s, c, p;
      repeat (6) @(posedge clock_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      rchk(BYTE_SEG_ATTR, 32'h0, 2'b00);
      rchk(BYTE_DIMM_POP, 32'h0, 2'b00);
      hcyc(20'hF0000, 1'b0, 1'b0, 1'b0, DEST_HUB);
      rchk(10'h3FC, 32'h0, 2'b11);
      // Every code in every segment; the next segment must stay disabled
      for (s = 0; s < 4; s++) begin
         for (c = 0; c < 4; c++) begin
            bus(1'b1, BYTE_SEG_ATTR, c << (2 * s), bq, br);
            hcyc({2'b11, s[1:0], 16'h1234}, 1'b0, 1'b0, 1'b0, c[0] ? DEST_DRAM : DEST_HUB);
            hcyc({2'b11, s[1:0], 16'hFFFF}, 1'b1, 1'b0, 1'b0, c[1] ? DEST_DRAM : DEST_HUB);
            hcyc({2'b11, s[1:0] + 2'd1, 16'h0}, 1'b0, 1'b0, 1'b0, DEST_HUB);
         end
      end
      bus(1'b1, BYTE_SEG_ATTR, 32'h0C, bq, br);
      hcyc(20'hDC000, 1'b0, 1'b0, 1'b0, DEST_DRAM);
      bus(1'b1, BYTE_HUB_CFG, 32'h01, bq, br);
      hcyc(20'hDC000, 1'b1, 1'b0, 1'b0, DEST_HUB);
      hcyc(20'hDFFFF, 1'b0, 1'b0, 1'b0, DEST_HUB);
      hcyc(20'hDBFFF, 1'b0, 1'b0, 1'b0, DEST_DRAM);
      bus(1'b1, BYTE_SEG_ATTR, 32'hFF, bq, br);
      hcyc(20'hA0000, 1'b0, 1'b0, 1'b0, DEST_HUB);
      bus(1'b1, BYTE_SYS_MGMT_RAM_CONTROL_CTL, 32'h01, bq, br);
      hcyc(20'hBFFFF, 1'b1, 1'b0, 1'b0, DEST_GFX);
      bus(1'b1, BYTE_SYS_MGMT_RAM_CONTROL_CTL, 32'h03, bq, br);
      hcyc(20'hA8000, 1'b0, 1'b1, 1'b0, DEST_REFUSE);
      hcyc(20'hA8000, 1'b1, 1'b0, 1'b1, DEST_DRAM);
      hcyc(20'hB0000, 1'b0, 1'b0, 1'b0, DEST_GFX);
      // Population codes on both DIMMs; pairs with code 2 left out, so DIMM1 also misses 13 and DIMM0 misses 7
      for (c = 0; c < 16; c++) begin
         p = (c + 5) % 16;
         if (c != 2 && p != 2) begin
            bus(1'b1, BYTE_DIMM_POP, {24'h0, c[3:0], p[3:0]}, bq, br);
            rchk(BYTE_DIMM_POP, {24'h0, c[3:0], p[3:0]}, 2'b00);
            @(posedge clock_i);
            #1;
            chk("dimm1_size", d1, size_tab[c]);
            chk("dimm0_size", d0, size_tab[p]);
            chk("total_size", tot, size_tab[c] + size_tab[p]);
         end
      end
      bus(1'b1, BYTE_DIMM_POP, 32'h96, bq, br);
      bus(1'b1, BYTE_SYS_MGMT_RAM_CONTROL_CTL, 32'h10, bq, br);
      bus(1'b1, BYTE_DIMM_POP, 32'h11, bq, br);
      rchk(BYTE_DIMM_POP, 32'h96, 2'b00);
      rchk(BYTE_STATUS, 32'h0000_1013, 2'b00);
      tally_and_finish();
   end
   // Hang guard
   initial begin
      repeat (50000) @(posedge clock_i);
      err_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
